// ---- nda_core_model.sv ----
// Behavioural processor core driving the register port and the code read port
`timescale 1ns/100ps
`default_nettype none
module nda_core_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  output logic code_rd_en,
  output logic [6:0] code_rd_addr,
  input wire logic [7:0] code_rd_data
);
  // Quiet bus from time zero; the code address is unread until its first request
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    code_rd_en = 1'b0;
  end

  // One write; keep holds the strobe for a back-to-back follower
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit keep);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    if (!keep) begin
      // Released lines show the inverse, so a stale value never looks valid
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
      @(posedge clk);
    end
  endtask : wr

  // One read; data sampled in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd

  // Code-memory move read of one stored byte
  task automatic cr(input logic [6:0] a, output logic [7:0] d);
    code_rd_en <= 1'b1;
    code_rd_addr <= a;
    @(posedge clk);
    code_rd_en <= 1'b0;
    code_rd_addr <= ~a;
    @(posedge clk);
    d = code_rd_data;
  endtask : cr

  // Key pair written back to back, then the release cycle and k more idle cycles
  task automatic unlock(input int k);
    wr(nda_pkg::KEY_OFS, nda_pkg::KEY_FIRST, 1'b1);
    wr(nda_pkg::KEY_OFS, nda_pkg::KEY_SECOND, 1'b0);
    repeat (k) @(posedge clk);
  endtask : unlock

  // Low address load; software keeps the top bit clear
  task automatic set_addr(input logic [6:0] a);
    wr(nda_pkg::LOW_ADDR_OFS, {1'b0, a}, 1'b0);
  endtask : set_addr
endmodule : nda_core_model
`default_nettype wire

// ---- nda_link_if.sv ----
// Signals between the register front end, the unlock sequencer and the store
`timescale 1ns/100ps
`default_nettype none
interface nda_link_if;
  logic bus_wr;
  logic key_wr;
  logic [7:0] key_data;
  logic window_open;
  logic erase_start;
  logic write_start;
  logic [6:0] nvm_addr;
  logic [7:0] nvm_wdata;
  logic busy;
  logic erasing;
  logic writing;
  logic rd_en;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;

  modport ctl (output bus_wr, key_wr, key_data, erase_start, write_start, nvm_addr,
    nvm_wdata, rd_en, rd_addr, input window_open, busy, erasing, writing, rd_data);
  modport unlock (input bus_wr, key_wr, key_data, output window_open);
  modport store (input erase_start, write_start, nvm_addr, nvm_wdata, rd_en, rd_addr,
    output busy, erasing, writing, rd_data);
endinterface : nda_link_if
`default_nettype wire

// ---- nda_pkg.sv ----
// Constants and types shared by the data-store access block
package nda_pkg;
  // Register offsets on the special-function-register port
  localparam logic [7:0] LOW_ADDR_OFS = 8'hC6;
  localparam logic [7:0] KEY_OFS = 8'hC7;
  localparam logic [7:0] CTRL_OFS = 8'hCE;
  localparam logic [7:0] DATA_OFS = 8'hCF;

  // Unlock key values, in the order they must arrive
  localparam logic [7:0] KEY_FIRST = 8'hAA;
  localparam logic [7:0] KEY_SECOND = 8'h55;

  // Control register fields and the top bit of the low address
  localparam int ERASE_BIT = 7;
  localparam int WRITE_BIT = 6;
  localparam int LOW_ADDR_MSB = 6;

  // Store geometry
  localparam int PAGES = 8;
  localparam int PAGE_BYTES = 16;
  localparam int ADDR_W = 7;

  // Timing: window length in machine cycles, clocks per machine cycle, op lengths
  localparam int UNLOCK_MC = 3;
  localparam int MC_CLKS = 1;
  localparam int ERASE_CLKS = 64;
  localparam int WRITE_CLKS = 16;

  // Reset and erased values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  typedef enum {KEY_IDLE, KEY_ARMED} nda_key_e;
  typedef enum {NV_IDLE, NV_ERASE, NV_WRITE} nda_nvm_e;
endpackage : nda_pkg

// ---- nda_store.sv ----
// Paged byte store with timed page erase, timed byte write and read port
`timescale 1ns/100ps
`default_nettype none
module nda_store #(
  parameter int ERASE_CLKS = nda_pkg::ERASE_CLKS,
  parameter int WRITE_CLKS = nda_pkg::WRITE_CLKS
) (
  input wire logic clk,
  input wire logic reset,
  nda_link_if.store lk
);
  localparam int DEPTH = nda_pkg::PAGES * nda_pkg::PAGE_BYTES;
  localparam int E_LAST = ERASE_CLKS - 1;
  localparam int W_LAST = WRITE_CLKS - 1;

  // Span checks use the counts as delay bounds, so they stay at or below 1000
  if (ERASE_CLKS < 1 || ERASE_CLKS > 1000 || WRITE_CLKS < 1 || WRITE_CLKS > 1000 ||
      DEPTH != (1 << nda_pkg::ADDR_W)) begin : g_bad_cfg
    $error("store timing or geometry out of range");
  end

  // Page base of a byte address; the low bits select the byte in the page
  function automatic logic [6:0] page_base(input logic [6:0] a);
    return a & ~7'(nda_pkg::PAGE_BYTES - 1);
  endfunction : page_base

  logic [7:0] mem [0:DEPTH-1];
  nda_pkg::nda_nvm_e state;
  logic [15:0] cnt;
  logic [6:0] op_addr;
  logic [7:0] op_data;
  wire logic op_done;

  assign lk.busy = (state != nda_pkg::NV_IDLE);
  assign lk.erasing = (state == nda_pkg::NV_ERASE);
  assign lk.writing = (state == nda_pkg::NV_WRITE);
  assign op_done = lk.busy && (cnt == 16'h0001);

  // Operation sequencer; operands latched so later register writes cannot disturb them
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= nda_pkg::NV_IDLE;
      cnt <= 16'h0000;
      op_addr <= nda_pkg::ADDR_RESET;
      op_data <= nda_pkg::REG_RESET;
    end else if (lk.erase_start && !lk.busy) begin
      state <= nda_pkg::NV_ERASE;
      cnt <= 16'(ERASE_CLKS);
      op_addr <= lk.nvm_addr;
    end else if (lk.write_start && !lk.busy) begin
      state <= nda_pkg::NV_WRITE;
      cnt <= 16'(WRITE_CLKS);
      op_addr <= lk.nvm_addr;
      op_data <= lk.nvm_wdata;
    end else if (op_done) begin
      state <= nda_pkg::NV_IDLE;
      cnt <= 16'h0000;
    end else if (lk.busy) begin
      cnt <= cnt - 16'h0001;
    end
  end

  // Array update at the end of each operation; contents survive reset
  always_ff @(posedge clk) begin
    if (op_done && lk.erasing) begin
      for (int i = 0; i < nda_pkg::PAGE_BYTES; i++) begin
        mem[page_base(op_addr) + 7'(i)] <= nda_pkg::ERASED_BYTE;
      end
    end else if (op_done && lk.writing) begin
      mem[op_addr] <= op_data;
    end
  end

  // Code-memory read port, one cycle latency
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lk.rd_data <= nda_pkg::REG_RESET;
    end else if (lk.rd_en) begin
      lk.rd_data <= mem[lk.rd_addr];
    end
  end

  a_erase_span: assert property (@(posedge clk) disable iff (reset)
    $rose(lk.erasing) |-> ##[E_LAST:E_LAST] lk.busy ##1 !lk.busy)
    else $error("erase length wrong");
  a_write_span: assert property (@(posedge clk) disable iff (reset)
    $rose(lk.writing) |-> ##[W_LAST:W_LAST] lk.busy ##1 !lk.busy)
    else $error("write length wrong");
  a_page_erased: assert property (@(posedge clk) disable iff (reset)
    op_done && lk.erasing |=>
      mem[page_base($past(op_addr)) + 7'(nda_pkg::PAGE_BYTES - 1)] == nda_pkg::ERASED_BYTE)
    else $error("page not erased");
  a_byte_lands: assert property (@(posedge clk) disable iff (reset)
    op_done && lk.writing |=> mem[$past(op_addr)] == $past(op_data))
    else $error("byte not stored");
  a_read_path: assert property (@(posedge clk) disable iff (reset)
    lk.rd_en && !op_done |=> lk.rd_data == mem[$past(lk.rd_addr)])
    else $error("read data wrong");
endmodule : nda_store
`default_nettype wire

// ---- nda_top.sv ----
// Data-store access block: register front end, unlock gate and operation control
//
// Overview of operation
// - Key opens protected writes for three machine cycles
// - Page follows from the low address register
// - Erase bit erases page and stalls core
// - Write bit stores byte and stalls core
// - Data register holds the byte to write
// - Bytes read back via code-memory move path
// - Low address uses bits 6:0, bit 7 zero
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module nda_top #(
  parameter int MC_CLKS = nda_pkg::MC_CLKS,
  parameter int ERASE_CLKS = nda_pkg::ERASE_CLKS,
  parameter int WRITE_CLKS = nda_pkg::WRITE_CLKS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic code_rd_en,
  input wire logic [6:0] code_rd_addr,
  output logic [7:0] code_rd_data,
  output logic core_stall
);
  nda_link_if lk ();

  // Software-visible state
  logic [6:0] low_addr;
  logic [7:0] data_byte;

  // Address decode
  wire logic hit_low;
  wire logic hit_key;
  wire logic hit_ctrl;
  wire logic hit_data;
  wire logic wr_low;
  wire logic wr_ctrl;
  wire logic wr_data;

  // Protected control write qualification
  wire logic ctrl_accept;
  wire logic want_erase;
  wire logic want_write;

  // Read selection
  wire logic [7:0] ctrl_view;
  wire logic [7:0] key_view;
  wire logic [7:0] low_view;
  wire logic [7:0] rd_mux;

  assign hit_low = (reg_addr == nda_pkg::LOW_ADDR_OFS);
  assign hit_key = (reg_addr == nda_pkg::KEY_OFS);
  assign hit_ctrl = (reg_addr == nda_pkg::CTRL_OFS);
  assign hit_data = (reg_addr == nda_pkg::DATA_OFS);
  assign wr_low = reg_wr && hit_low;
  assign wr_ctrl = reg_wr && hit_ctrl;
  assign wr_data = reg_wr && hit_data;

  // Every write reaches the sequencer so an interleaved write breaks the key pair
  assign lk.bus_wr = reg_wr;
  assign lk.key_wr = reg_wr && hit_key;
  assign lk.key_data = reg_wdata;

  // Control bits only take effect inside the window and with the store idle
  assign ctrl_accept = wr_ctrl && lk.window_open && !lk.busy;
  assign want_erase = reg_wdata[nda_pkg::ERASE_BIT];
  assign want_write = reg_wdata[nda_pkg::WRITE_BIT];

  // Erase wins if both bits are set in one write; a zero starts nothing
  assign lk.erase_start = ctrl_accept && want_erase;
  assign lk.write_start = ctrl_accept && !want_erase && want_write;

  // Operands come straight from the registers; no page-enable step exists
  assign lk.nvm_addr = low_addr;
  assign lk.nvm_wdata = data_byte;

  // Core code-memory reads pass to the store
  assign lk.rd_en = code_rd_en;
  assign lk.rd_addr = code_rd_addr;
  assign code_rd_data = lk.rd_data;

  // Core held while an operation runs; released the cycle it ends
  assign core_stall = lk.busy;

  // Control bits read back as the operation in flight
  assign ctrl_view = {lk.erasing, lk.writing, 6'h00};
  // Key register shows only whether the window is open
  assign key_view = {7'h00, lk.window_open};
  // Bit 7 of the address is not stored and reads zero
  assign low_view = {1'b0, low_addr};

  assign rd_mux = hit_low ? low_view :
    hit_key ? key_view :
    hit_ctrl ? ctrl_view :
    hit_data ? data_byte :
    nda_pkg::REG_RESET;

  // Low address register; bit 7 dropped so software cannot leave the store
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_addr <= nda_pkg::ADDR_RESET;
    end else if (wr_low) begin
      low_addr <= reg_wdata[nda_pkg::LOW_ADDR_MSB:0];
    end
  end

  // Byte to be written by the next write operation
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      data_byte <= nda_pkg::REG_RESET;
    end else if (wr_data) begin
      data_byte <= reg_wdata;
    end
  end

  // Read data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= nda_pkg::REG_RESET;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= nda_pkg::REG_RESET;
    end
  end

  // Key sequencer and timed window
  nda_unlock #(
    .MC_CLKS(MC_CLKS)
  ) u_unlock (
    .clk(clk),
    .reset(reset),
    .lk(lk.unlock)
  );

  // Byte store with erase and write timing
  nda_store #(
    .ERASE_CLKS(ERASE_CLKS),
    .WRITE_CLKS(WRITE_CLKS)
  ) u_store (
    .clk(clk),
    .reset(reset),
    .lk(lk.store)
  );

  // Checks on the front end

  a_page_from_addr: assert property (@(posedge clk) disable iff (reset)
    lk.erase_start |=> lk.erasing && $past(lk.nvm_addr) == $past(low_addr))
    else $error("erase did not use low address");

  a_erase_stalls: assert property (@(posedge clk) disable iff (reset)
    lk.erase_start |=> core_stall && reg_rdata == 8'h00 ##0 lk.erasing)
    else $error("erase did not stall the core");

  a_write_stalls: assert property (@(posedge clk) disable iff (reset)
    lk.write_start |=> core_stall && lk.writing && !lk.erasing)
    else $error("write did not stall the core");

  a_stall_release: assert property (@(posedge clk) disable iff (reset)
    $fell(lk.busy) |-> !core_stall && $past(core_stall))
    else $error("stall not released with the operation");

  a_clear_no_op: assert property (@(posedge clk) disable iff (reset)
    wr_ctrl && !want_erase && !want_write |-> !lk.erase_start && !lk.write_start)
    else $error("clearing control bits started an operation");

  a_locked_ignore: assert property (@(posedge clk) disable iff (reset)
    wr_ctrl && !lk.window_open && !lk.busy |=> !lk.busy)
    else $error("locked control write took effect");

  a_open_accepts: assert property (@(posedge clk) disable iff (reset)
    wr_ctrl && lk.window_open && !lk.busy && want_write |=> lk.busy)
    else $error("open-window control write ignored");

  a_data_hold: assert property (@(posedge clk) disable iff (reset)
    wr_data |=> data_byte == $past(reg_wdata))
    else $error("data register did not load");

  a_addr_bit7: assert property (@(posedge clk) disable iff (reset)
    reg_rd && hit_low |=> reg_rdata[7] == 1'b0 && reg_rdata[6:0] == $past(low_addr))
    else $error("low address read wrong");

  a_read_one_cycle: assert property (@(posedge clk) disable iff (reset)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");

  a_store_readback: assert property (@(posedge clk) disable iff (reset)
    code_rd_en |=> code_rd_data == lk.rd_data)
    else $error("code read path broken");
endmodule : nda_top
`default_nettype wire

// ---- nda_unlock.sv ----
// Two-write key sequencer and timed window for protected control bits
`timescale 1ns/100ps
`default_nettype none
module nda_unlock #(
  parameter int MC_CLKS = nda_pkg::MC_CLKS
) (
  input wire logic clk,
  input wire logic reset,
  nda_link_if.unlock lk
);
  localparam int WIN_CLKS = nda_pkg::UNLOCK_MC * MC_CLKS;
  localparam int CNT_W = $clog2(WIN_CLKS + 1);
  localparam logic [CNT_W-1:0] WIN_LOAD = CNT_W'(WIN_CLKS);

  if (MC_CLKS < 1) begin : g_bad_mc
    $error("MC_CLKS must be at least one");
  end

  nda_pkg::nda_key_e state;
  nda_pkg::nda_key_e next_state;
  logic [CNT_W-1:0] win_cnt;
  logic [CNT_W-1:0] next_win_cnt;
  logic [CNT_W:0] age;
  wire logic first_ok;
  wire logic key_done;

  // Any other write between the two keys breaks the sequence
  assign first_ok = lk.key_wr && (lk.key_data == nda_pkg::KEY_FIRST);
  assign key_done = (state == nda_pkg::KEY_ARMED) && lk.key_wr &&
    (lk.key_data == nda_pkg::KEY_SECOND);
  assign next_state = !lk.bus_wr ? state :
    (first_ok ? nda_pkg::KEY_ARMED : nda_pkg::KEY_IDLE);
  assign next_win_cnt = key_done ? WIN_LOAD :
    ((win_cnt != '0) ? win_cnt - 1'b1 : win_cnt);
  assign lk.window_open = (win_cnt != '0);

  // Sequencer state and window countdown
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= nda_pkg::KEY_IDLE;
      win_cnt <= '0;
    end else begin
      state <= next_state;
      win_cnt <= next_win_cnt;
    end
  end

  // Cycles since the last completed key, saturating; only the checks read it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      age <= '1;
    end else if (key_done) begin
      age <= '0;
    end else if (age != '1) begin
      age <= age + 1'b1;
    end
  end

  a_window_holds: assert property (@(posedge clk) disable iff (reset)
    key_done |=> lk.window_open [*3])
    else $error("window shut early");
  a_window_shuts: assert property (@(posedge clk) disable iff (reset)
    lk.window_open |-> (age < (CNT_W+1)'(WIN_CLKS)))
    else $error("window open too long");
  a_open_cause: assert property (@(posedge clk) disable iff (reset)
    $rose(lk.window_open) |-> $past(key_done))
    else $error("window opened without key pair");
endmodule : nda_unlock
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the data-store access block
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int EC = 4;
  localparam int WC = 2;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic code_rd_en;
  logic [6:0] code_rd_addr;
  logic [7:0] code_rd_data;
  logic core_stall;
  int num_errors = 0;
  int compares = 0;
  logic [7:0] v;
  logic [7:0] offs [5] = '{nda_pkg::LOW_ADDR_OFS, nda_pkg::KEY_OFS, nda_pkg::CTRL_OFS,
    nda_pkg::DATA_OFS, 8'h10};
  logic [6:0] ca [3] = '{7'h20, 7'h2F, 7'h30};
  logic [7:0] cd [3] = '{8'hA5, 8'h3C, 8'hC3};

  // Short counts keep the stall checks quick
  nda_top #(.MC_CLKS(1), .ERASE_CLKS(EC), .WRITE_CLKS(WC)) dut (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .code_rd_en(code_rd_en),
    .code_rd_addr(code_rd_addr), .code_rd_data(code_rd_data), .core_stall(core_stall)
  );

  nda_core_model core (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .code_rd_en(code_rd_en),
    .code_rd_addr(code_rd_addr), .code_rd_data(code_rd_data)
  );

  // 125 MHz clock
  always #4 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Counts stalled cycles; entered one edge after the control write is taken
  task automatic run_op(input int exp);
    int n;
    n = 0;
    while (core_stall === 1'b1 && n < 1000) begin
      n++;
      @(posedge clk);
    end
    chk(n[15:0], exp[15:0]);
  endtask : run_op

  // Byte write issued in the last open cycle of the window
  task automatic store_byte(input logic [6:0] a, input logic [7:0] d);
    core.set_addr(a);
    core.wr(nda_pkg::DATA_OFS, d, 1'b0);
    core.unlock(1);
    core.wr(nda_pkg::CTRL_OFS, 8'h40, 1'b0);
    run_op(WC);
  endtask : store_byte

  task automatic finish_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // Cuts a hang well past the expected run of about 130 cycles
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    finish_test();
  end

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // Reset values, unmapped place included
    foreach (offs[i]) begin
      core.rd(offs[i], v);
      chk(v, 8'h00);
    end
    core.set_addr(7'h7F);
    core.rd(nda_pkg::LOW_ADDR_OFS, v);
    chk(v, 8'h7F);
    core.wr(nda_pkg::DATA_OFS, 8'h5A, 1'b0);
    core.rd(nda_pkg::DATA_OFS, v);
    chk(v, 8'h5A);
    // Control write with no window open
    core.wr(nda_pkg::CTRL_OFS, 8'h40, 1'b0);
    chk(core_stall, 1'b0);
    core.rd(nda_pkg::CTRL_OFS, v);
    chk(v, 8'h00);
    // Key broken by another write, then a wrong second key
    core.wr(nda_pkg::KEY_OFS, nda_pkg::KEY_FIRST, 1'b0);
    core.wr(nda_pkg::DATA_OFS, 8'h5A, 1'b0);
    core.wr(nda_pkg::KEY_OFS, nda_pkg::KEY_SECOND, 1'b0);
    core.wr(nda_pkg::CTRL_OFS, 8'h40, 1'b0);
    chk(core_stall, 1'b0);
    core.wr(nda_pkg::KEY_OFS, nda_pkg::KEY_FIRST, 1'b1);
    core.wr(nda_pkg::KEY_OFS, 8'h54, 1'b0);
    core.wr(nda_pkg::CTRL_OFS, 8'h40, 1'b0);
    chk(core_stall, 1'b0);
    // Key register shows the open window; the read ends in its last cycle
    core.unlock(0);
    core.rd(nda_pkg::KEY_OFS, v);
    chk(v, 8'h01);
    // One cycle past the window
    core.wr(nda_pkg::CTRL_OFS, 8'h40, 1'b0);
    chk(core_stall, 1'b0);
    core.rd(nda_pkg::KEY_OFS, v);
    chk(v, 8'h00);
    // Bytes in two pages, read back on the code path
    foreach (ca[i]) store_byte(ca[i], cd[i]);
    foreach (ca[i]) begin
      core.cr(ca[i], v);
      chk(v, cd[i]);
    end
    // Erase the page selected by an address inside it
    core.set_addr(7'h25);
    core.unlock(0);
    core.wr(nda_pkg::CTRL_OFS, 8'h80, 1'b0);
    // Control shows the erase in flight; the read spends two stalled cycles
    core.rd(nda_pkg::CTRL_OFS, v);
    chk(v, 8'h80);
    run_op(EC - 2);
    core.rd(nda_pkg::CTRL_OFS, v);
    chk(v, 8'h00);
    foreach (ca[i]) begin
      core.cr(ca[i], v);
      chk(v, (i < 2) ? nda_pkg::ERASED_BYTE : cd[i]);
    end
    // A cleared control write starts nothing; with both bits set erase wins
    core.set_addr(7'h30);
    core.unlock(0);
    core.wr(nda_pkg::CTRL_OFS, 8'h00, 1'b1);
    core.wr(nda_pkg::CTRL_OFS, 8'hC0, 1'b0);
    run_op(EC);
    core.cr(7'h30, v);
    chk(v, nda_pkg::ERASED_BYTE);
    finish_test();
  end
endmodule : tb
`default_nettype wire
